//--- rtl/lmfc_counter.sv
// Free running LMFC phase counter for one dual, with rotation load
`timescale 1ns/100ps
`default_nettype none
module lmfc_counter #(
  parameter int unsigned PERIOD = 64
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Rotation request
  input wire logic rotate,
  // Phase out
  output logic [$clog2(PERIOD)-1:0] phase
);
  localparam int unsigned PW = $clog2(PERIOD);
  localparam logic [PW-1:0] LAST = PW'(PERIOD - 1);
  localparam logic [PW-1:0] ALIGNED = PW'(1);
  typedef struct packed {
    logic [PW-1:0] cnt;
  } cnt_s;
  cnt_s s_q;
  cnt_s s_d;
  always_comb begin
    s_d = s_q;
    if (rotate) begin
      // Edge sits at phase zero; next cycle continues from one
      s_d.cnt = ALIGNED;
    end else if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + PW'(1);
    end
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign phase = s_q.cnt;
endmodule : lmfc_counter
`default_nettype wire

//--- rtl/lmfc_edge_detect.sv
// Synchroniser and rising edge detector for the alignment edge input
`timescale 1ns/100ps
`default_nettype none
module lmfc_edge_detect (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Level in, pulse out
  input wire logic level_in,
  output logic rise_pulse
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } edge_s;
  edge_s s_q;
  edge_s s_d;
  always_comb begin
    s_d = s_q;
    s_d.meta = level_in;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // High level seen after a low one forms the edge
  assign rise_pulse = s_q.sync & ~s_q.last;
endmodule : lmfc_edge_detect
`default_nettype wire

//--- rtl/lmfc_sync_machine.sv
// LMFC sync machine: register file, phase check and rotation control
// Operation
// - keep one LMFC per dual, aligned to processing clock or SYSREF by subclass
// - SYSREF is active high, sampled on device clock rising edges
// - accept single pulse, step, continuous, strobed or gapped SYSREF
// - compare LMFC phase at each edge the mode checks and rotate when out of phase
// - mode 0x01 checks only first edge after arming, rotates beyond window
// - mode 0x02 checks every edge without arming; Subclass 1 periodic only
// - edges arriving during a rotation are ignored
// - with nonzero window, measure each checked edge, align only beyond tolerance (mode 0x09 first armed edge aligns regardless of window)
// - window code 0 is half clock, codes 1 to 3 are 1 to 3 clocks
// - arm bit self clears on an edge; in continuous mode it only reports
// - mode 0x09 aligns on first armed edge, then only measures and reports
// - current error register reads zero after alignment, updates on each phase check
// - low or high exceeded flag set when error beyond window
// - at alignment, snapshot last error and its flags
// - enable bit 7, arm bit 6, mode in bits 3 to 0 of control
// - busy flag high while a sync operation is in progress
// - lock and window limit flags update on every phase check
// - sticky rotation flag set on alignment, cleared by clear-sticky write
// - sticky trip flag set on each phase check, cleared by clear-sticky write
// - lock, rotation, trip and window flags offered as per-dual events
`timescale 1ns/100ps
`default_nettype none
module lmfc_sync_machine
  import lmfc_sync_pkg::*;
#(
  parameter int unsigned LMFC_PERIOD = LMFC_PERIOD_DEFAULT,
  parameter int unsigned ROTATE_CYCLES = ROTATE_CYCLES_DEFAULT,
  parameter int unsigned PROC_EDGE_DIV = PROC_EDGE_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Alignment sources
  input wire logic sysref,
  input wire logic subclass1,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [lmfc_sync_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lmfc_sync_pkg::DATA_W-1:0] reg_wdata,
  output logic [lmfc_sync_pkg::DATA_W-1:0] reg_rdata,
  // LMFC phases and per-dual events: lock, rotation, trip, window limit
  output logic [$clog2(LMFC_PERIOD)-1:0] lmfc_phase_a,
  output logic [$clog2(LMFC_PERIOD)-1:0] lmfc_phase_b,
  output logic [3:0] sync_events_a,
  output logic [3:0] sync_events_b
);
  import lmfc_sync_pkg::*;
  localparam int unsigned PW = $clog2(LMFC_PERIOD);
  localparam int unsigned RW = $clog2(ROTATE_CYCLES + 1);
  localparam int unsigned DW = $clog2(PROC_EDGE_DIV);
  localparam logic [RW-1:0] ROT_LOAD = RW'(ROTATE_CYCLES);
  localparam logic [DW-1:0] DIV_LAST = DW'(PROC_EDGE_DIV - 1);
  localparam int HALF = LMFC_PERIOD / 2;

  typedef struct packed {
    sync_state_e state;
    logic [7:0] dual_select;
    logic [7:0] tolerance;
    logic enable;
    logic arm;
    logic [3:0] mode;
    logic busy;
    logic lock;
    logic rotated;
    logic wlim;
    logic trip;
    logic [7:0] cur_err;
    logic err_low;
    logic err_high;
    logic [7:0] snap_err;
    logic [1:0] snap_flags;
    logic armed_once;
    logic [RW-1:0] rot_cnt;
    logic [DW-1:0] div_cnt;
    logic [7:0] meas;
    logic [1:0] rot_duals;
    logic [7:0] rdata;
  } sync_s;

  sync_s s_q;
  sync_s s_d;
  logic sysref_rise;
  logic align_edge;
  logic [1:0] rotate_dual;
  logic [PW-1:0] phase_a;

  // Signed distance from the edge to the nearest LMFC boundary, in DAC clocks
  function automatic logic [7:0] phase_error(input logic [PW-1:0] ph);
    int e;
    e = int'(ph);
    if (e >= HALF) begin
      e = e - int'(LMFC_PERIOD);
    end
    if (e > 127) begin
      e = 127;
    end else if (e < -128) begin
      e = -128;
    end
    return 8'(e);
  endfunction : phase_error

  // Tolerance in half DAC clocks: code 0 is one half, code n is 2n halves
  function automatic logic beyond_window(input logic [7:0] err, input logic [2:0] tol);
    int mag2;
    int lim2;
    mag2 = 2 * ((err[7]) ? -int'($signed(err)) : int'(err));
    lim2 = (tol == 3'h0) ? 1 : 2 * int'(tol);
    return mag2 > lim2;
  endfunction : beyond_window

  lmfc_edge_detect u_sysref_edge (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .level_in(sysref),
    .rise_pulse(sysref_rise)
  );

  lmfc_counter #(.PERIOD(LMFC_PERIOD)) u_lmfc_a (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .rotate(rotate_dual[0]),
    .phase(phase_a)
  );

  lmfc_counter #(.PERIOD(LMFC_PERIOD)) u_lmfc_b (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .rotate(rotate_dual[1]),
    .phase(lmfc_phase_b)
  );

  assign lmfc_phase_a = phase_a;
  // Subclass 1 uses SYSREF; Subclass 0 an internal processing clock edge
  assign align_edge = subclass1 ? sysref_rise : (s_q.div_cnt == DIV_LAST);
  // The duals set in dual_select rotate together at the end of the rotation cycle
  assign rotate_dual = (s_q.state == ST_ROTATE && s_q.rot_cnt == RW'(1)) ? s_q.rot_duals : 2'b00;

  always_comb begin
    logic mode_ok;
    logic check;
    logic do_align;
    logic over;
    logic [7:0] err;
    mode_ok = 1'b0;
    check = 1'b0;
    do_align = 1'b0;
    over = 1'b0;
    err = phase_error(phase_a);
    s_d = s_q;
    s_d.div_cnt = (s_q.div_cnt == DIV_LAST) ? '0 : s_q.div_cnt + DW'(1);
    mode_ok = (s_q.mode == MODE_ONE_SHOT) || (s_q.mode == MODE_CONTINUOUS) ||
              (s_q.mode == MODE_ONE_SHOT_MONITOR);
    over = beyond_window(err, s_q.tolerance[2:0]);

    // Register writes
    if (reg_wr) begin
      if (reg_addr == DUAL_SELECT_ADDR) begin
        s_d.dual_select = reg_wdata;
      end else if (reg_addr == PHASE_WINDOW_TOLERANCE_ADDR) begin
        s_d.tolerance = {5'h00, reg_wdata[2:0]};
      end else if (reg_addr == SYNC_CONTROL_ADDR) begin
        s_d.enable = reg_wdata[CTRL_ENABLE_BIT];
        s_d.mode = reg_wdata[3:0];
        if (reg_wdata[CTRL_ARM_BIT]) begin
          s_d.arm = 1'b1;
          s_d.armed_once = 1'b0;
        end
        if (reg_wdata[CTRL_CLR_STICKY_BIT]) begin
          s_d.rotated = 1'b0;
          s_d.trip = 1'b0;
        end
      end
    end

    case (s_q.state)
      ST_IDLE: begin
        s_d.busy = 1'b0;
        if (s_q.enable && mode_ok && align_edge) begin
          // Arm self-clears on every edge in modes 0x01, 0x02 and 0x09
          s_d.arm = 1'b0;
          if (s_q.mode == MODE_CONTINUOUS) begin
            check = 1'b1;
            do_align = over;
          end else if (s_q.mode == MODE_ONE_SHOT) begin
            check = s_q.arm;
            do_align = s_q.arm && over;
          end else begin
            check = s_q.arm || s_q.armed_once;
            do_align = s_q.arm;
            s_d.armed_once = s_q.armed_once | s_q.arm;
          end
        end
        if (check) begin
          s_d.trip = 1'b1;
          s_d.wlim = over;
          s_d.lock = ~over;
          s_d.cur_err = err;
          s_d.err_low = over & err[7];
          s_d.err_high = over & ~err[7];
          s_d.meas = err;
        end
        if (do_align) begin
          s_d.snap_err = err;
          // Snapshot carries the exceeded flags as the check sees them
          s_d.snap_flags = {over & err[7], over & ~err[7]};
          s_d.rot_duals = s_q.dual_select[1:0] & DUALS_ALL;
          s_d.busy = 1'b1;
          s_d.rot_cnt = ROT_LOAD;
          s_d.state = ST_ROTATE;
        end else if (check && s_q.arm && s_q.mode != MODE_CONTINUOUS) begin
          // First armed check already in window: counts as aligned
          s_d.cur_err = 8'h00;
          s_d.busy = 1'b1;
          s_d.state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        s_d.busy = 1'b0;
        s_d.state = ST_IDLE;
      end
      ST_ROTATE: begin
        // Edges are not looked at here
        s_d.rot_cnt = s_q.rot_cnt - RW'(1);
        if (s_q.rot_cnt == RW'(1)) begin
          s_d.rotated = 1'b1;
          s_d.lock = 1'b1;
          s_d.wlim = 1'b0;
          s_d.cur_err = 8'h00;
          s_d.err_low = 1'b0;
          s_d.err_high = 1'b0;
          s_d.busy = 1'b0;
          s_d.state = ST_IDLE;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase

    // Read data
    if (reg_rd) begin
      if (reg_addr == DUAL_SELECT_ADDR) begin
        s_d.rdata = s_q.dual_select;
      end else if (reg_addr == PHASE_WINDOW_TOLERANCE_ADDR) begin
        s_d.rdata = s_q.tolerance;
      end else if (reg_addr == PHASE_ERROR_SNAPSHOT_ADDR) begin
        s_d.rdata = s_q.snap_err;
      end else if (reg_addr == ERROR_FLAG_SNAPSHOT_ADDR) begin
        s_d.rdata = {s_q.snap_flags, 6'h00};
      end else if (reg_addr == SYNC_CONTROL_ADDR) begin
        s_d.rdata = {s_q.enable, s_q.arm, 2'b00, s_q.mode};
      end else if (reg_addr == SYNC_STATUS_ADDR) begin
        s_d.rdata = {s_q.busy, 3'b000, s_q.lock, s_q.rotated, s_q.wlim, s_q.trip};
      end else if (reg_addr == CURRENT_PHASE_ERROR_ADDR) begin
        s_d.rdata = s_q.cur_err;
      end else if (reg_addr == WINDOW_EXCEEDED_FLAGS_ADDR) begin
        s_d.rdata = {s_q.err_low, s_q.err_high, 6'h00};
      end else begin
        s_d.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.state <= ST_IDLE;
      s_q.dual_select <= DUAL_SELECT_RESET;
      s_q.tolerance <= TOLERANCE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  // Event vector per dual, gated by dual selection
  assign sync_events_a = s_q.dual_select[0] ? {s_q.lock, s_q.rotated, s_q.trip, s_q.wlim} : 4'h0;
  assign sync_events_b = s_q.dual_select[1] ? {s_q.lock, s_q.rotated, s_q.trip, s_q.wlim} : 4'h0;
endmodule : lmfc_sync_machine
`default_nettype wire

//--- rtl/lmfc_sync_pkg.sv
// Constants and types shared by the LMFC sync machine
package lmfc_sync_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam logic [11:0] DUAL_SELECT_ADDR = 12'h008;
  localparam logic [11:0] PHASE_WINDOW_TOLERANCE_ADDR = 12'h034;
  localparam logic [11:0] PHASE_ERROR_SNAPSHOT_ADDR = 12'h038;
  localparam logic [11:0] ERROR_FLAG_SNAPSHOT_ADDR = 12'h039;
  localparam logic [11:0] SYNC_CONTROL_ADDR = 12'h03A;
  localparam logic [11:0] SYNC_STATUS_ADDR = 12'h03B;
  localparam logic [11:0] CURRENT_PHASE_ERROR_ADDR = 12'h03C;
  localparam logic [11:0] WINDOW_EXCEEDED_FLAGS_ADDR = 12'h03D;
  localparam int unsigned CTRL_ENABLE_BIT = 7;
  localparam int unsigned CTRL_ARM_BIT = 6;
  localparam int unsigned CTRL_CLR_STICKY_BIT = 5;
  localparam int unsigned STAT_BUSY_BIT = 7;
  localparam int unsigned STAT_LOCK_BIT = 3;
  localparam int unsigned STAT_ROT_BIT = 2;
  localparam int unsigned STAT_WLIM_BIT = 1;
  localparam int unsigned STAT_TRIP_BIT = 0;
  localparam int unsigned FLAG_LOW_BIT = 7;
  localparam int unsigned FLAG_HIGH_BIT = 6;
  localparam logic [3:0] MODE_ONE_SHOT = 4'h1;
  localparam logic [3:0] MODE_CONTINUOUS = 4'h2;
  localparam logic [3:0] MODE_ONE_SHOT_MONITOR = 4'h9;
  localparam logic [7:0] DUAL_SELECT_RESET = 8'h00;
  localparam logic [7:0] TOLERANCE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] DUALS_ALL = 2'h3;
  localparam int unsigned LMFC_PERIOD_DEFAULT = 64;
  localparam int unsigned ROTATE_CYCLES_DEFAULT = 8;
  localparam int unsigned PROC_EDGE_DIV_DEFAULT = 256;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_ROTATE = 2'b11
  } sync_state_e;
endpackage : lmfc_sync_pkg

//--- tb/lmfc_sync_chk.sv
// Port-level assertion checker for the LMFC sync machine
`timescale 1ns/100ps
`default_nettype none
module lmfc_sync_chk
  import lmfc_sync_pkg::*;
#(
  parameter int unsigned LMFC_PERIOD = 64
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Alignment sources
  input wire logic sysref,
  input wire logic subclass1,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [lmfc_sync_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lmfc_sync_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [lmfc_sync_pkg::DATA_W-1:0] reg_rdata,
  // Dual A phase and events
  input wire logic [$clog2(LMFC_PERIOD)-1:0] lmfc_phase_a,
  input wire logic [3:0] sync_events_a
);
  localparam int PW = $clog2(LMFC_PERIOD);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  phase_step_a: assert property (
    $past(arst_n) |-> lmfc_phase_a == PW'($past(lmfc_phase_a) + 1) || lmfc_phase_a == PW'(1))
    else $error("LMFC phase neither stepped nor reloaded");
  tol_readback_a: assert property (
    reg_wr && reg_addr == PHASE_WINDOW_TOLERANCE_ADDR ##1 !reg_wr ##1 reg_rd && reg_addr == PHASE_WINDOW_TOLERANCE_ADDR
    |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3)) else $error("Tolerance readback differs");
  ctrl_readback_a: assert property (
    reg_wr && reg_addr == SYNC_CONTROL_ADDR && !reg_wdata[6] ##1 !reg_wr ##1 reg_rd && reg_addr == SYNC_CONTROL_ADDR
    |=> {reg_rdata[7:6], reg_rdata[3:0]} == {$past(reg_wdata[7], 3), 1'b0, $past(reg_wdata[3:0], 3)})
    else $error("Control readback differs");
  clr_write_only_a: assert property (
    reg_rd && reg_addr == SYNC_CONTROL_ADDR |=> !reg_rdata[5]) else $error("Clear sticky bit reads high");
  trip_cause_a: assert property (
    $rose(sync_events_a[1]) && subclass1 && $past(subclass1, 4) && !$past(reg_wr)
    |-> $past(sysref, 2) || $past(sysref, 3) || $past(sysref, 4)) else $error("Trip set without an edge");
  trip_sticky_a: assert property (
    $fell(sync_events_a[1]) |-> $past(reg_wr)) else $error("Trip flag dropped without a write");
  rot_sticky_a: assert property (
    $fell(sync_events_a[2]) |-> $past(reg_wr)) else $error("Rotation flag dropped without a write");
  wflags_excl_a: assert property (
    reg_rd && reg_addr == WINDOW_EXCEEDED_FLAGS_ADDR |=> !(reg_rdata[7] && reg_rdata[6]) && reg_rdata[5:0] == 6'h00)
    else $error("Low and high exceeded flags both set");
  rot_lock_a: assert property (
    $rose(sync_events_a[2]) |-> sync_events_a[3]) else $error("Rotation without lock");

  cover property ($rose(sync_events_a[2]));
  cover property ($rose(sync_events_a[1]) && !subclass1);
  cover property (reg_wr && reg_addr == PHASE_WINDOW_TOLERANCE_ADDR ##2 reg_rd);
endmodule : lmfc_sync_chk
`default_nettype wire

//--- tb/sysref_source.sv
// SYSREF source model: one active high pulse per request
`timescale 1ns/100ps
`default_nettype none
module sysref_source (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Pulse request
  input wire logic fire,
  input wire logic [2:0] width,
  // Alignment edge out
  output logic sysref
);
  logic [2:0] cnt_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 3'h0;
    end else if (fire) begin
      cnt_q <= width;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  // Level changes just after the device clock edge
  assign sysref = (cnt_q != 3'h0);
endmodule : sysref_source
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the LMFC sync machine
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import lmfc_sync_pkg::*;
  localparam int unsigned PER = 16;
  localparam int unsigned DIV = 16;
  logic sys_clk, arst_n, subclass1, reg_wr, reg_rd, fire, rd_q;
  logic [2:0] width;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [3:0] lmfc_phase_a, lmfc_phase_b, sync_events_a, sync_events_b;
  wire logic sysref;
  logic [31:0] lfsr;
  logic [15:0] exp_q[$];
  int num_errors, samples_checked;

  lmfc_sync_machine #(.LMFC_PERIOD(PER), .ROTATE_CYCLES(4), .PROC_EDGE_DIV(DIV)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .sysref(sysref), .subclass1(subclass1), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lmfc_phase_a(lmfc_phase_a), .lmfc_phase_b(lmfc_phase_b), .sync_events_a(sync_events_a),
    .sync_events_b(sync_events_b));
  sysref_source src (.sys_clk(sys_clk), .arst_n(arst_n), .fire(fire), .width(width), .sysref(sysref));

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Expected value and mask are noted before the read is issued
  task automatic rd(input logic [11:0] a, input logic [7:0] want, input logic [7:0] mask);
    exp_q.push_back({want, mask});
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic pulse();
    lfsr = step(lfsr);
    @(posedge sys_clk);
    fire <= 1'b1;
    width <= 3'(2 + lfsr[1:0]);
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (24 + lfsr[7:4]) @(posedge sys_clk);
  endtask : pulse
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Read data is valid the cycle after the read strobe is taken
  always @(posedge sys_clk) begin
    logic [15:0] e;
    if (rd_q) begin
      e = exp_q.pop_front();
      check(reg_rdata & e[7:0], e[15:8] & e[7:0]);
    end
    rd_q <= reg_rd;
  end

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (4000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    lfsr = 32'hdf6c;
    num_errors = 0;
    samples_checked = 0;
    rd_q = 1'b0;
    arst_n = 1'b0;
    subclass1 = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fire = 1'b0;
    width = 3'h0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(SYNC_CONTROL_ADDR, CONTROL_RESET, 8'hff);
    rd(SYNC_STATUS_ADDR, 8'h00, 8'hff);
    rd(12'h0ff, 8'h00, 8'hff);
    wr(DUAL_SELECT_ADDR, 8'h03);
    rd(DUAL_SELECT_ADDR, 8'h03, 8'hff);
    lfsr = step(lfsr);
    wr(PHASE_WINDOW_TOLERANCE_ADDR, {6'h00, lfsr[1:0]});
    rd(PHASE_WINDOW_TOLERANCE_ADDR, {6'h00, lfsr[1:0]}, 8'h07);
    wr(SYNC_CONTROL_ADDR, 8'h85);
    pulse();
    rd(SYNC_STATUS_ADDR, 8'h00, 8'h8f);
    wr(SYNC_CONTROL_ADDR, 8'h41);
    pulse();
    rd(SYNC_STATUS_ADDR, 8'h00, 8'h8f);
    wr(SYNC_CONTROL_ADDR, 8'h81);
    wr(SYNC_CONTROL_ADDR, 8'hc1);
    pulse();
    rd(SYNC_CONTROL_ADDR, 8'h81, 8'hff);
    rd(SYNC_STATUS_ADDR, 8'h09, 8'h89);
    check({sync_events_a & 4'ha, sync_events_b & 4'ha}, 8'haa);
    wr(SYNC_CONTROL_ADDR, 8'ha1);
    rd(SYNC_STATUS_ADDR, 8'h00, 8'h05);
    pulse();
    rd(SYNC_STATUS_ADDR, 8'h00, 8'h01);
    wr(SYNC_CONTROL_ADDR, 8'h82);
    rd(SYNC_CONTROL_ADDR, 8'h82, 8'hff);
    pulse();
    rd(SYNC_STATUS_ADDR, 8'h01, 8'h81);
    wr(SYNC_CONTROL_ADDR, 8'ha2);
    pulse();
    rd(SYNC_STATUS_ADDR, 8'h01, 8'h01);
    wr(SYNC_CONTROL_ADDR, 8'hc2);
    pulse();
    rd(SYNC_CONTROL_ADDR, 8'h82, 8'hff);
    wr(PHASE_WINDOW_TOLERANCE_ADDR, TOLERANCE_RESET);
    wr(SYNC_CONTROL_ADDR, 8'hc9);
    pulse();
    rd(SYNC_STATUS_ADDR, 8'h09, 8'h89);
    rd(CURRENT_PHASE_ERROR_ADDR, 8'h00, 8'hff);
    rd(WINDOW_EXCEEDED_FLAGS_ADDR, 8'h00, 8'hff);
    rd(ERROR_FLAG_SNAPSHOT_ADDR, 8'h00, 8'h3f);
    wr(SYNC_CONTROL_ADDR, 8'ha9);
    pulse();
    rd(SYNC_STATUS_ADDR, 8'h01, 8'h05);
    rd(WINDOW_EXCEEDED_FLAGS_ADDR, 8'h00, 8'h3f);
    check(8'(lmfc_phase_b ^ lmfc_phase_a), 8'h00);
    subclass1 <= 1'b0;
    wr(SYNC_CONTROL_ADDR, 8'ha1);
    wr(SYNC_CONTROL_ADDR, 8'hc1);
    repeat (3 * DIV) @(posedge sys_clk);
    rd(SYNC_STATUS_ADDR, 8'h01, 8'h81);
    wr(DUAL_SELECT_ADDR, 8'h00);
    @(posedge sys_clk);
    check({sync_events_a, sync_events_b}, 8'h00);
    repeat (2) @(posedge sys_clk);
    give_verdict();
  end
endmodule : testbench

bind lmfc_sync_machine lmfc_sync_chk #(.LMFC_PERIOD(LMFC_PERIOD)) chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .sysref(sysref), .subclass1(subclass1), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lmfc_phase_a(lmfc_phase_a), .sync_events_a(sync_events_a));
`default_nettype wire
